/* File: rtl/zqc_ctrl.v */
/*
  Impedance calibration command interpreter for one flash target.
  Assumes the command bus strobes arrive from pins and are
  synchronised here; data and address are stable around the strobes.
*/
`include "zqc_consts.vh"

module zqc_ctrl #(
  parameter          CODE_W        = `ZQC_CODE_W,
  parameter          HAS_OVERDRIVE = 1,
  parameter [15:0]   LONG_CYC      = `ZQC_LONG_CYC,
  parameter [15:0]   SHORT_CYC     = `ZQC_SHORT_CYC,
  parameter [15:0]   RESET_CYC     = `ZQC_RESET_CYC
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              sys_rst_i,
  // Command bus pins
  input  wire              cle_pin_i,
  input  wire              ale_pin_i,
  input  wire              we_pin_i,
  input  wire              re_pin_i,
  input  wire [7:0]        dq_pin_i,
  output reg  [7:0]        dq_o,
  output wire              dq_oe_o,
  output wire              odt_en_o,
  // Ready/busy and analog side
  output wire              ready_busy_indicator_o,
  input  wire              cmp_high_i,
  output reg  [CODE_W-1:0] imp_code_o,
  output reg  [1:0]        drive_sel_o,
  output reg  [1:0]        lun_sel_o,
  output wire              cal_pass_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_CAL   = 3'h2;
  localparam [2:0] ST_RST   = 3'h3;
  localparam [2:0] ST_FADDR = 3'h4;
  localparam [2:0] ST_FDATA = 3'h5;
  localparam [2:0] ST_STAT  = 3'h6;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [3:0]  sync1_reg;
  reg  [3:0]  sync2_reg;
  reg  [7:0]  dq1_reg;
  reg  [7:0]  dq2_reg;
  reg         we_d_reg;
  reg         re_d_reg;
  reg         cmp1_reg;
  reg         cmp2_reg;

  // Stage bit order: 3 read enable, 2 address latch, 1 write enable, 0 command latch
  // Comparator is asynchronous to this clock and gets the same two stages
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      dq1_reg   <= 8'h00;
      dq2_reg   <= 8'h00;
      we_d_reg  <= 1'b0;
      re_d_reg  <= 1'b0;
      cmp1_reg  <= 1'b0;
      cmp2_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= {re_pin_i, ale_pin_i, we_pin_i, cle_pin_i};
      sync2_reg <= sync1_reg;
      dq1_reg   <= dq_pin_i;
      dq2_reg   <= dq1_reg;
      we_d_reg  <= sync2_reg[1];
      re_d_reg  <= sync2_reg[3];
      cmp1_reg  <= cmp_high_i;
      cmp2_reg  <= cmp1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  // A cycle is taken once, on the clock after the synchronised write
  // enable rises; latch enables and the byte pass the same stages
  wire       cle      = sync2_reg[0];
  wire       ale      = sync2_reg[2];
  wire       we_rise  = sync2_reg[1] & ~we_d_reg;
  wire       re_fall  = ~sync2_reg[3] & re_d_reg;
  wire       cmd_stb  = we_rise & cle & ~ale;
  wire       addr_stb = we_rise & ale & ~cle;
  wire       data_stb = we_rise & ~cle & ~ale;

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] cnt_reg;
  reg         is_long_reg;
  reg         pass_reg;
  reg         fail_reg;
  reg  [1:0]  fdata_cnt_reg;

  wire              eng_done;
  wire              eng_pass;
  wire [CODE_W-1:0] eng_code;
  wire              cal_start = (state_reg == ST_ADDR) && addr_stb &&
                                (dq2_reg == `ZQC_LUN0 || dq2_reg == `ZQC_LUN1);
  wire              cal_abort = (state_reg == ST_CAL) && cmd_stb &&
                                (dq2_reg == `ZQC_OP_RESET);

  // ----------------------------------------------------------------
  // Impedance search
  // ----------------------------------------------------------------
  // The done edge adds one busy cycle, so the engine runs one cycle
  // less than the whole busy budget
  wire [15:0]       cal_budget = is_long_reg ? LONG_CYC - 16'h0001 :
                                               SHORT_CYC - 16'h0001;

  zqc_engine #(
    .CODE_W     (CODE_W)
  ) zqc_engine_i (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (cal_start),
    .abort_i    (cal_abort),
    .budget_i   (cal_budget),
    .cmp_high_i (cmp2_reg),
    .code_o     (eng_code),
    .done_o     (eng_done),
    .pass_o     (eng_pass)
  );

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_STAT:
      begin
        if (cmd_stb)
        begin
          case (dq2_reg)
            `ZQC_OP_LONG,
            `ZQC_OP_SHORT:    state_next = ST_ADDR;
            `ZQC_OP_SET_FEAT: state_next = ST_FADDR;
            `ZQC_OP_STATUS:   state_next = ST_STAT;
            `ZQC_OP_RESET:    state_next = ST_RST;
            default:          state_next = ST_IDLE;
          endcase
        end
      end
      ST_ADDR:
      begin
        // Only a valid LUN byte lets the opcode start a search
        if (addr_stb)
          state_next = cal_start ? ST_CAL : ST_IDLE;
        else if (cmd_stb)
          state_next = ST_IDLE;
      end
      ST_CAL:
      begin
        if (cal_abort)
          state_next = ST_RST;
        else if (eng_done)
          state_next = ST_IDLE;
      end
      ST_RST:
      begin
        // Counter is loaded on entry; leave on its last count
        if (cnt_reg <= 16'h0001)
          state_next = ST_IDLE;
      end
      ST_FADDR:
      begin
        if (addr_stb)
          state_next = (dq2_reg == `ZQC_FA_DRIVE) ? ST_FDATA : ST_IDLE;
        else if (cmd_stb)
          state_next = ST_IDLE;
      end
      ST_FDATA:
      begin
        // A stray command drops the rest of the feature write
        if (data_stb && fdata_cnt_reg == 2'h3)
          state_next = ST_IDLE;
        else if (cmd_stb)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 16'h0000;
      is_long_reg   <= 1'b0;
      pass_reg      <= 1'b0;
      fail_reg      <= 1'b0;
      fdata_cnt_reg <= 2'h0;
      imp_code_o    <= `ZQC_CODE_DEFAULT;
      drive_sel_o   <= `ZQC_DRV_NOM;
      lun_sel_o     <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != ST_ADDR && cmd_stb &&
          (dq2_reg == `ZQC_OP_LONG || dq2_reg == `ZQC_OP_SHORT))
        is_long_reg <= (dq2_reg == `ZQC_OP_LONG);
      if (cal_start)
      begin
        lun_sel_o <= dq2_reg[0] ? 2'h2 : 2'h1;
        pass_reg  <= 1'b0;
        fail_reg  <= 1'b0;
      end
      if (state_next == ST_RST && state_reg != ST_RST)
        cnt_reg <= RESET_CYC;
      else if (state_reg == ST_RST && cnt_reg != 16'h0000)
        cnt_reg <= cnt_reg - 16'h0001;
      // An abort drops the search result; only a long one restores the code
      if (cal_abort)
      begin
        fail_reg <= 1'b1;
        if (is_long_reg)
          imp_code_o <= `ZQC_CODE_DEFAULT;
      end
      else if (state_reg == ST_CAL && eng_done)
      begin
        pass_reg <= eng_pass;
        fail_reg <= ~eng_pass;
        imp_code_o <= eng_pass ? eng_code : `ZQC_CODE_DEFAULT;
      end
      if (state_reg == ST_FADDR)
        fdata_cnt_reg <= 2'h0;
      else if (state_reg == ST_FDATA && data_stb)
      begin
        fdata_cnt_reg <= fdata_cnt_reg + 2'h1;
        // Unsupported overdrive codes are ignored
        if (fdata_cnt_reg == 2'h0 &&
            (HAS_OVERDRIVE != 0 || dq2_reg[1:0] == `ZQC_DRV_NOM ||
             dq2_reg[1:0] == `ZQC_DRV_UD))
          drive_sel_o <= dq2_reg[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status byte and outputs
  // ----------------------------------------------------------------
  // Busy covers the search and the reset count; status is served outside it
  wire busy = (state_reg == ST_CAL) || (state_reg == ST_RST);

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
      dq_o <= 8'h00;
    else if (state_reg == ST_STAT && re_fall)
    begin
      dq_o                <= 8'h00;
      dq_o[`ZQC_ST_FAIL]  <= fail_reg;
      dq_o[`ZQC_ST_RDY]   <= ~busy;
      dq_o[`ZQC_ST_WP_N]  <= 1'b1;
    end
  end

  assign dq_oe_o                = (state_reg == ST_STAT) & ~sync2_reg[3] & ~busy;
  assign odt_en_o               = ~busy;
  assign ready_busy_indicator_o = ~busy;
  assign cal_pass_o             = pass_reg;

endmodule // zqc_ctrl

/* File: rtl/zqc_consts.vh */
/*
  Constants for the impedance calibration command block.
  Assumes a 100 MHz clock on the command interface side.
*/
`ifndef ZQC_CONSTS_VH
`define ZQC_CONSTS_VH

// ----------------------------------------------------------------
// Opcodes, LUN select values and feature address
// ----------------------------------------------------------------
`define ZQC_OP_LONG        8'hF9
`define ZQC_OP_SHORT       8'hD9
`define ZQC_OP_RESET       8'hFF
`define ZQC_OP_STATUS      8'h70
`define ZQC_OP_SET_FEAT    8'hEF
`define ZQC_LUN0           8'h00
`define ZQC_LUN1           8'h01
`define ZQC_FA_DRIVE       8'h10

// ----------------------------------------------------------------
// Timing, in ns, and derived cycle counts at 10 ns
// ----------------------------------------------------------------
`define ZQC_CLK_NS         10
`define ZQC_LONG_NS        1000
`define ZQC_SHORT_NS       300
`define ZQC_RESET_NS       10000
`define ZQC_LONG_CYC       (`ZQC_LONG_NS / `ZQC_CLK_NS)
`define ZQC_SHORT_CYC      (`ZQC_SHORT_NS / `ZQC_CLK_NS)
`define ZQC_RESET_CYC      (`ZQC_RESET_NS / `ZQC_CLK_NS)

// ----------------------------------------------------------------
// Driver strength codes
// ----------------------------------------------------------------
`define ZQC_DRV_OD2        2'h0
`define ZQC_DRV_OD1        2'h1
`define ZQC_DRV_NOM        2'h2
`define ZQC_DRV_UD         2'h3

// ----------------------------------------------------------------
// Status byte bits
// ----------------------------------------------------------------
`define ZQC_ST_FAIL        0
`define ZQC_ST_RDY         6
`define ZQC_ST_WP_N        7

// ----------------------------------------------------------------
// Impedance code width and default
// ----------------------------------------------------------------
`define ZQC_CODE_W         6
`define ZQC_CODE_DEFAULT   6'h20

`endif

/* File: rtl/zqc_engine.v */
/*
  Impedance search engine: steps the code toward the comparator
  and reports done and pass. Assumes comparator input synchronised.
*/
`include "zqc_consts.vh"

module zqc_engine #(
  parameter CODE_W = `ZQC_CODE_W
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              sys_rst_i,
  // Control
  input  wire              start_i,
  input  wire              abort_i,
  input  wire [15:0]       budget_i,
  // Comparator: high when the driver is still too weak
  input  wire              cmp_high_i,
  // Results
  output reg  [CODE_W-1:0] code_o,
  output reg               done_o,
  output reg               pass_o
);

  reg  [15:0] cnt_reg;
  reg         run_reg;
  reg         last_reg;
  reg  [2:0]  flips_reg;

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_reg   <= 16'h0000;
      run_reg   <= 1'b0;
      last_reg  <= 1'b0;
      flips_reg <= 3'h0;
      code_o    <= {CODE_W{1'b0}};
      done_o    <= 1'b0;
      pass_o    <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (abort_i)
        run_reg <= 1'b0;
      else if (start_i)
      begin
        run_reg   <= 1'b1;
        cnt_reg   <= budget_i;
        flips_reg <= 3'h0;
        code_o    <= `ZQC_CODE_DEFAULT;
        last_reg  <= cmp_high_i;
      end
      else if (run_reg)
      begin
        // Settles when the comparator has toggled a few times
        if (cmp_high_i != last_reg && flips_reg != 3'h7)
          flips_reg <= flips_reg + 3'h1;
        last_reg <= cmp_high_i;
        if (cmp_high_i && code_o != {CODE_W{1'b1}})
          code_o <= code_o + {{(CODE_W-1){1'b0}}, 1'b1};
        else if (!cmp_high_i && code_o != {CODE_W{1'b0}})
          code_o <= code_o - {{(CODE_W-1){1'b0}}, 1'b1};
        if (cnt_reg <= 16'h0001)
        begin
          run_reg <= 1'b0;
          done_o  <= 1'b1;
          pass_o  <= (flips_reg >= 3'h2);
        end
        else
          cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

endmodule // zqc_engine

/* File: tb/zqc_ctrl_chk.sv */
/*
  Port assertions for the calibration command block.
  Assumes bind to zqc_ctrl; pins move off the rising edge.
*/
`include "zqc_consts.vh"

module zqc_ctrl_chk #(
  parameter        CODE_W    = `ZQC_CODE_W,
  parameter [15:0] LONG_CYC  = `ZQC_LONG_CYC,
  parameter [15:0] SHORT_CYC = `ZQC_SHORT_CYC,
  parameter [15:0] RESET_CYC = `ZQC_RESET_CYC
) (
  // Clock, reset and pins
  input wire              clk_i,
  input wire              sys_rst_i,
  input wire              cle_pin_i,
  input wire              ale_pin_i,
  input wire              we_pin_i,
  input wire [7:0]        dq_pin_i,
  // Outputs
  input wire [7:0]        dq_o,
  input wire              dq_oe_o,
  input wire              odt_en_o,
  input wire              ready_busy_indicator_o,
  input wire [CODE_W-1:0] imp_code_o,
  input wire [1:0]        drive_sel_o,
  input wire [1:0]        lun_sel_o,
  input wire              cal_pass_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        we_q;
  logic        pend_q;
  logic [7:0]  op_q;
  logic [7:0]  kind_q;
  logic [7:0]  addr_q;
  logic [15:0] busy_q;
  wire         rdy = ready_busy_indicator_o;
  wire         stb = we_pin_i & ~we_q;
  wire         sh_abort = (op_q == `ZQC_OP_RESET) && (kind_q == `ZQC_OP_SHORT);
  wire [15:0]  lim = (op_q == `ZQC_OP_LONG) ? LONG_CYC - 16'h0001 :
                     (op_q == `ZQC_OP_SHORT) ? SHORT_CYC - 16'h0001 : RESET_CYC + 16'h0005;

  // Reset command restarts the busy count, sync delay allowed for
  always @(posedge clk_i)
  begin
    we_q   <= we_pin_i;
    busy_q <= (rdy || (stb && cle_pin_i)) ? 16'h0000 : busy_q + 16'h0001;
    if (rdy)
      kind_q <= op_q;
    if (stb && cle_pin_i)
      op_q <= dq_pin_i;
    if (stb)
      pend_q <= cle_pin_i && (dq_pin_i == `ZQC_OP_LONG || dq_pin_i == `ZQC_OP_SHORT);
    if (stb && ale_pin_i)
      addr_q <= dq_pin_i;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_lun_ok;
    stb && ale_pin_i && pend_q && dq_pin_i[7:1] == 7'h00;
  endsequence
  sequence s_lun_bad;
    stb && ale_pin_i && pend_q && dq_pin_i[7:1] != 7'h00;
  endsequence

  AST_CAL_START: assert property (s_lun_ok |-> ##[2:7] !rdy)
    else $error("no busy after calibration");
  AST_LUN_REFUSED: assert property (s_lun_bad |-> ##1 rdy [*8])
    else $error("bad lun started calibration");
  AST_BUSY_BOUND: assert property (!rdy |-> busy_q <= lim)
    else $error("busy too long");
  AST_ODT_OFF: assert property (!rdy |-> !odt_en_o && !dq_oe_o)
    else $error("bus not quiet while busy");
  AST_DRIVE_HOLD: assert property (!rdy |=> $stable(drive_sel_o))
    else $error("strength moved while busy");
  AST_PASS_CLEAR: assert property ($fell(rdy) |=> !cal_pass_o)
    else $error("pass flag kept at start");
  AST_LUN_SEL: assert property ($rose(rdy) && op_q != `ZQC_OP_RESET
    |=> lun_sel_o == {addr_q[0], !addr_q[0]}) else $error("wrong lun");
  AST_FAIL_DEFAULT: assert property ($rose(rdy) && !cal_pass_o && !sh_abort
    |-> imp_code_o == `ZQC_CODE_DEFAULT) else $error("code not default");
  AST_STATUS: assert property ($past(dq_oe_o) && dq_oe_o
    |-> dq_o[7:6] == 2'b11 && dq_o[0] == !cal_pass_o) else $error("bad status");
endmodule // zqc_ctrl_chk

bind zqc_ctrl zqc_ctrl_chk #(.CODE_W(CODE_W), .LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC),
  .RESET_CYC(RESET_CYC)) zqc_ctrl_chk_i (.clk_i, .sys_rst_i, .cle_pin_i, .ale_pin_i,
  .we_pin_i, .dq_pin_i, .dq_o, .dq_oe_o, .odt_en_o, .ready_busy_indicator_o, .imp_code_o,
  .drive_sel_o, .lun_sel_o, .cal_pass_o);

/* File: tb/zqc_host_model.sv */
/*
  Host on the command bus: sends cycles and reads status.
  Assumes its tasks are called just after a falling edge.
*/
`include "zqc_consts.vh"

module zqc_host_model (
  // Clock
  input wire         clk_i,
  // Command bus
  output logic       cle_o,
  output logic       ale_o,
  output logic       we_o,
  output logic       re_o,
  output logic [7:0] dq_o,
  // Status from the device
  input wire [7:0]   st_i,
  input wire         st_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {cle_o, ale_o, we_o, re_o, dq_o} = {4'h1, 8'h00};
  end

  // Kind 0 command, 1 address, 2 data; a released byte is inverted
  task automatic put(input logic [1:0] kind, input logic [7:0] val);
    cle_o = kind == 2'h0;
    ale_o = kind == 2'h1;
    dq_o = val;
    repeat (3) @(negedge clk_i);
    we_o = 1'b1;
    repeat (3) @(negedge clk_i);
    we_o = 1'b0;
    repeat (3) @(negedge clk_i);
    {cle_o, ale_o, dq_o} = {2'h0, ~val};
    @(negedge clk_i);
  endtask

  task automatic status(output logic [7:0] val);
    put(2'h0, `ZQC_OP_STATUS);
    re_o = 1'b0;
    repeat (5) @(negedge clk_i);
    val = st_oe_i ? st_i : 8'h00;
    re_o = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
endmodule // zqc_host_model

/* File: tb/nand_zq_calibration_control_tb_top.sv */
/*
  Testbench for zqc_ctrl with a host model on the command bus.
  Assumes shortened busy counts; the comparator is modelled here.
*/
`include "zqc_consts.vh"

module nand_zq_calibration_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] LONG_C  = 16'h0028;
  localparam [15:0] SHORT_C = 16'h000C;
  localparam [15:0] RST_C   = 16'h003C;
  logic       clk_i;
  logic       sys_rst_i;
  logic       cmp_high_i = 1'b0;
  logic       cmp_good;
  logic [7:0] st;
  wire        cle_pin_i;
  wire        ale_pin_i;
  wire        we_pin_i;
  wire        re_pin_i;
  wire [7:0]  dq_pin_i;
  wire [7:0]  dq_o;
  wire        dq_oe_o;
  wire        odt_en_o;
  wire        ready_busy_indicator_o;
  wire [5:0]  imp_code_o;
  wire [1:0]  drive_sel_o;
  wire [1:0]  lun_sel_o;
  wire        cal_pass_o;
  int         fail_count = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         n;

  zqc_ctrl #(.LONG_CYC(LONG_C), .SHORT_CYC(SHORT_C), .RESET_CYC(RST_C)) zqc_ctrl_i (
    .clk_i, .sys_rst_i, .cle_pin_i, .ale_pin_i, .we_pin_i, .re_pin_i, .dq_pin_i, .dq_o,
    .dq_oe_o, .odt_en_o, .ready_busy_indicator_o, .cmp_high_i, .imp_code_o, .drive_sel_o,
    .lun_sel_o, .cal_pass_o);
  zqc_host_model zqc_host_model_i (.clk_i, .cle_o(cle_pin_i), .ale_o(ale_pin_i),
    .we_o(we_pin_i), .re_o(re_pin_i), .dq_o(dq_pin_i), .st_i(dq_o), .st_oe_i(dq_oe_o));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Comparator toggles for a good search and sticks high for a bad one
  always @(negedge clk_i)
    cmp_high_i <= cmp_good ? ~cmp_high_i : 1'b1;
  // Whole run needs about 550 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_max(input string what, input int lim, input int got);
    n_tests++;
    if (got > lim)
    begin
      fail_count++;
      $display("wrong value %s expected <= %0d seen %0d", what, lim, got);
    end
  endtask
  task automatic cy(input logic [1:0] kind, input logic [7:0] val);
    zqc_host_model_i.put(kind, val);
  endtask
  task automatic run_cal(input logic [7:0] op, input logic [7:0] lun, input logic abort);
    n = 0;
    cy(2'h0, op);
    cy(2'h1, lun);
    chk("busy", 16'h0000, ready_busy_indicator_o);
    if (abort)
      cy(2'h0, `ZQC_OP_RESET);
    while (ready_busy_indicator_o !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic chk_end(input logic pass, input logic [1:0] lun);
    chk("pass", pass, cal_pass_o);
    chk("lun", lun, lun_sel_o);
    zqc_host_model_i.status(st);
    chk("status", {2'b11, ~pass}, {st[7:6], st[0]});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("reset", {2'b11, `ZQC_CODE_DEFAULT, `ZQC_DRV_NOM, 1'b0},
      {ready_busy_indicator_o, odt_en_o, imp_code_o, drive_sel_o, cal_pass_o});
    $display("test reset done");
  endtask
  task automatic t_drive;
    for (int s = 3; s >= 0; s--)
    begin
      cy(2'h0, `ZQC_OP_SET_FEAT);
      cy(2'h1, `ZQC_FA_DRIVE);
      for (int b = 0; b < 4; b++)
        cy(2'h2, (b == 0) ? 8'(s) : 8'h00);
      chk("drive", 16'(s), drive_sel_o);
    end
    $display("test drive done");
  endtask
  task automatic t_long_pass;
    cmp_good = 1'b1;
    run_cal(`ZQC_OP_LONG, `ZQC_LUN1, 1'b0);
    chk_max("long busy", LONG_C, n);
    chk_end(1'b1, 2'b10);
    $display("test long_pass done");
  endtask
  task automatic t_short_fail;
    cmp_good = 1'b0;
    run_cal(`ZQC_OP_SHORT, `ZQC_LUN0, 1'b0);
    chk_max("short busy", SHORT_C, n);
    chk("code", `ZQC_CODE_DEFAULT, imp_code_o);
    chk_end(1'b0, 2'b01);
    cmp_good = 1'b1;
    $display("test short_fail done");
  endtask
  task automatic t_bad_lun;
    cy(2'h0, `ZQC_OP_LONG);
    cy(2'h1, 8'h02);
    chk("ready", 16'h0001, ready_busy_indicator_o);
    $display("test bad_lun done");
  endtask
  task automatic t_abort;
    run_cal(`ZQC_OP_LONG, `ZQC_LUN0, 1'b1);
    chk_max("reset busy", RST_C + 5, n);
    chk("code", `ZQC_CODE_DEFAULT, imp_code_o);
    chk("pass", 16'h0000, cal_pass_o);
    $display("test abort done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    cmp_good = 1'b1;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_drive();
    t_long_pass();
    t_short_fail();
    t_bad_lun();
    t_abort();
    t_long_pass();
    close_out();
  end
endmodule // nand_zq_calibration_control_tb_top
